// File: src/lcirq_pkg.sv
/*
 Package for the link-change interrupt block: register offsets, field positions,
 reset values. Assumes an 8-bit internal register port of the switch.
*/
package lcirq_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] LCIRQ_OFS_MASK = 8'hBB;
	localparam logic [7:0] LCIRQ_OFS_FLAGS = 8'hBC;
	localparam logic [7:0] LCIRQ_MASK_RST = 8'h00;
	localparam logic [7:0] LCIRQ_FLAGS_RST = 8'h00;
	// ==========================================================
	// Flag field positions
	localparam int LCIRQ_BIT_P12_ANA = 7;
	localparam int LCIRQ_BIT_P3_MII = 2;
	localparam int LCIRQ_BIT_P2_ANA = 1;
	localparam int LCIRQ_BIT_P1_ANY = 0;
	// Bits that hardware may hold; reserved 6-3 stay zero
	localparam logic [7:0] LCIRQ_FLAGS_LIVE = 8'h87;
endpackage

// File: src/lcirq_link_change.sv
/*
 Link-change interrupt logic: enable mask, sticky write-one-to-clear event flags
 and an active-low interrupt pin. Assumes link event inputs are one-cycle or level
 pulses synchronous to core_clk, and a simple internal register port.
*/
// Overview of operation
// - An eight-bit mask register, zero after reset, lets each flag bit reach the interrupt pin.
// - Flag bit 7 sets when port one or port two changes link on the copper side and holds until written one.
// - Flag bit 2 sets when port three changes link on its MII side and holds until written one.
// - Flag bit 1 sets when port two changes link on the copper side and holds until written one.
// - Flag bit 0 sets when port one changes link on either side and holds until written one.
// - All flags reset to zero and reserved bits 6 to 3 always read zero.
// - Pending enabled events are signalled on a dedicated interrupt pin.
`timescale 1ns/1ns
module lcirq_link_change
	import lcirq_pkg::*;
(
	input wire logic core_clk, // System clock, 100 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic [7:0] reg_addr, // Register address
	input wire logic reg_wr, // Write strobe, one cycle
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_rd, // Read strobe, one cycle
	output logic [7:0] reg_rdata_ff, // Read data, valid cycle after reg_rd
	input wire logic p1_ana_link_event, // Port one copper link changed
	input wire logic p1_mii_link_event, // Port one MII link changed
	input wire logic p2_ana_link_event, // Port two copper link changed
	input wire logic p3_mii_link_event, // Port three MII link changed
	output logic irq_out_n_ff // Interrupt pin, active low
);

	// ==========================================================
	// Register state
	logic [7:0] irq_mask_ff;
	logic [7:0] nxt_irq_mask;
	logic [7:0] link_event_flags_ff;
	logic [7:0] nxt_link_event_flags;
	logic [7:0] nxt_reg_rdata;
	logic nxt_irq_out_n;
	logic [7:0] event_set;
	logic [7:0] flag_clr;

	// Event sources mapped onto flag positions
	always_comb begin
		event_set = 8'h00;
		event_set[LCIRQ_BIT_P12_ANA] = p1_ana_link_event | p2_ana_link_event;
		event_set[LCIRQ_BIT_P3_MII] = p3_mii_link_event;
		event_set[LCIRQ_BIT_P2_ANA] = p2_ana_link_event;
		event_set[LCIRQ_BIT_P1_ANY] = p1_ana_link_event | p1_mii_link_event;
	end

	// Next values; a new event beats a same-cycle clear so no change is lost
	always_comb begin
		flag_clr = 8'h00;
		nxt_irq_mask = irq_mask_ff;
		if (reg_wr && reg_addr == LCIRQ_OFS_MASK) begin
			nxt_irq_mask = reg_wdata;
		end
		if (reg_wr && reg_addr == LCIRQ_OFS_FLAGS) begin
			flag_clr = reg_wdata;
		end
		nxt_link_event_flags = ((link_event_flags_ff & ~flag_clr) | event_set)
			& LCIRQ_FLAGS_LIVE;
		nxt_reg_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				LCIRQ_OFS_MASK: nxt_reg_rdata = irq_mask_ff;
				LCIRQ_OFS_FLAGS: nxt_reg_rdata = link_event_flags_ff;
				default: nxt_reg_rdata = 8'h00;
			endcase
		end
		// Uses next values so the pin follows the flags in the same cycle
		nxt_irq_out_n = ~|(nxt_link_event_flags & nxt_irq_mask);
	end

	// Registers only
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_mask_ff <= LCIRQ_MASK_RST;
			link_event_flags_ff <= LCIRQ_FLAGS_RST;
			reg_rdata_ff <= 8'h00;
			irq_out_n_ff <= 1'b1;
		end else begin
			irq_mask_ff <= nxt_irq_mask;
			link_event_flags_ff <= nxt_link_event_flags;
			reg_rdata_ff <= nxt_reg_rdata;
			irq_out_n_ff <= nxt_irq_out_n;
		end
	end

	// ==========================================================
	// Assertions
	sequence s_flag_clear;
		reg_wr && reg_addr == LCIRQ_OFS_FLAGS && reg_wdata[0] && !event_set[0];
	endsequence

	AST_MASK_RESET: assert property (@(posedge core_clk) srst |=> irq_mask_ff == 8'h00)
		else $error("mask not zero after reset");
	AST_BIT7_SET: assert property (@(posedge core_clk) disable iff (srst)
		(p1_ana_link_event || p2_ana_link_event) |=> link_event_flags_ff[7])
		else $error("flag 7 not set");
	AST_BIT2_SET: assert property (@(posedge core_clk) disable iff (srst)
		p3_mii_link_event |=> link_event_flags_ff[2])
		else $error("flag 2 not set");
	AST_BIT1_SET: assert property (@(posedge core_clk) disable iff (srst)
		p2_ana_link_event |=> link_event_flags_ff[1])
		else $error("flag 1 not set");
	AST_BIT0_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
		(p1_mii_link_event |=> link_event_flags_ff[0]) and (s_flag_clear |=> !link_event_flags_ff[0]))
		else $error("flag 0 set or clear wrong");
	// Disabled in reset: before the first reset edge the flags are still unknown
	AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (srst)
		link_event_flags_ff[6:3] == 4'h0)
		else $error("reserved flags not zero");
	AST_PIN_LEVEL: assert property (@(posedge core_clk) disable iff (srst)
		irq_out_n_ff == ~|(link_event_flags_ff & irq_mask_ff))
		else $error("interrupt pin disagrees with flags");
	AST_ZERO_WRITE_KEEPS: assert property (@(posedge core_clk) disable iff (srst)
		(reg_wr && reg_addr == LCIRQ_OFS_FLAGS && !reg_wdata[1] && link_event_flags_ff[1])
		|=> link_event_flags_ff[1])
		else $error("zero write cleared a flag");

	// ==========================================================
	// Reset values of the flags and the pin; the mask is checked in AST_MASK_RESET
	// The pin must come out of reset inactive, or the host would
	// take a false interrupt before it has programmed the mask.
	AST_FLAGS_RESET: assert property (@(posedge core_clk)
		srst |=> link_event_flags_ff == 8'h00)
		else $error("flags not zero after reset");
	AST_PIN_RESET: assert property (@(posedge core_clk)
		srst |=> irq_out_n_ff)
		else $error("interrupt pin active after reset");

	// ==========================================================
	// Mask register behaviour
	// A write to the mask address loads the whole byte
	AST_MASK_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		(reg_wr && reg_addr == LCIRQ_OFS_MASK) |=> irq_mask_ff == $past(reg_wdata))
		else $error("mask write not taken");
	// Any other cycle leaves the mask alone, so a stray flag write
	// can never open or close an interrupt source by accident
	AST_MASK_HOLD: assert property (@(posedge core_clk) disable iff (srst)
		!(reg_wr && reg_addr == LCIRQ_OFS_MASK) |=> irq_mask_ff == $past(irq_mask_ff))
		else $error("mask changed without a write");

	// ==========================================================
	// Flag clears by a write of one, one check each for bits 7, 2 and 1; bit 0 is in AST_BIT0_CLEAR
	// Each antecedent excludes a same-cycle event, since the event wins
	AST_BIT7_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
		(reg_wr && reg_addr == LCIRQ_OFS_FLAGS && reg_wdata[7]
		&& !p1_ana_link_event && !p2_ana_link_event) |=> !link_event_flags_ff[7])
		else $error("flag 7 not cleared");
	AST_BIT2_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
		(reg_wr && reg_addr == LCIRQ_OFS_FLAGS && reg_wdata[2] && !p3_mii_link_event)
		|=> !link_event_flags_ff[2])
		else $error("flag 2 not cleared");
	AST_BIT1_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
		(reg_wr && reg_addr == LCIRQ_OFS_FLAGS && reg_wdata[1] && !p2_ana_link_event)
		|=> !link_event_flags_ff[1])
		else $error("flag 1 not cleared");

	// ==========================================================
	// Flag 0 has two sources; the copper one is checked here
	AST_BIT0_ANA_SET: assert property (@(posedge core_clk) disable iff (srst)
		p1_ana_link_event |=> link_event_flags_ff[0])
		else $error("flag 0 not set by copper change");
	// An event that meets a clear in one cycle must survive it,
	// otherwise a link change during service would be lost
	AST_SET_BEATS_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
		(reg_wr && reg_addr == LCIRQ_OFS_FLAGS && reg_wdata[0] && event_set[0])
		|=> link_event_flags_ff[0])
		else $error("clear beat a same-cycle event");
	// Without an event a clear flag stays clear
	AST_NO_SPURIOUS_SET: assert property (@(posedge core_clk) disable iff (srst)
		(!link_event_flags_ff[0] && !event_set[0]) |=> !link_event_flags_ff[0])
		else $error("flag 0 set without an event");

	// ==========================================================
	// Read port
	// Read data is zero outside a read reply, so the host bus
	// can OR several register ports together without gating
	AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (srst)
		!reg_rd |=> reg_rdata_ff == 8'h00)
		else $error("read data not zero when idle");
	AST_RDATA_MASK: assert property (@(posedge core_clk) disable iff (srst)
		(reg_rd && reg_addr == LCIRQ_OFS_MASK) |=> reg_rdata_ff == $past(irq_mask_ff))
		else $error("mask read back wrong");
	// A read that meets a write shows the value from before the write
	AST_RDATA_FLAGS: assert property (@(posedge core_clk) disable iff (srst)
		(reg_rd && reg_addr == LCIRQ_OFS_FLAGS)
		|=> reg_rdata_ff == $past(link_event_flags_ff))
		else $error("flags read back wrong");
	AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (srst)
		(reg_rd && reg_addr != LCIRQ_OFS_MASK && reg_addr != LCIRQ_OFS_FLAGS)
		|=> reg_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
endmodule // lcirq_link_change

// File: verification/lcirq_host.sv
/* Host model: one-cycle register strobes. Assumes the bench supplies core_clk. */
`timescale 1ns/1ns
module lcirq_host (
	input wire logic core_clk, // Clock
	output logic [7:0] reg_addr = 8'h00, // Address
	output logic reg_wr = 1'h0, // Write strobe
	output logic [7:0] reg_wdata = 8'h00, // Data
	output logic reg_rd = 1'h0 // Read strobe
);
	// Strobes move 1 ns after an edge so the design never races them
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
		@(posedge core_clk) #1 reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk) #1 {reg_addr, reg_rd} = {a, 1'h1};
		@(posedge core_clk) #1 reg_rd = 1'h0;
	endtask
endmodule // lcirq_host

// File: verification/lcirq_link_change_tb.sv
/* Bench: event table, then hand cases. Assumes lcirq_host drives the port. */
`timescale 1ns/1ns
module lcirq_link_change_tb;
	logic core_clk = 1'h0, srst = 1'h1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
	logic reg_wr, reg_rd, irq_out_n_ff;
	logic [3:0] ev = 4'h0; // P3 MII, P2 copper, P1 MII, P1 copper
	int err_total = 0, cmp_count = 0;
	logic [11:0] rows [4] = '{12'h181, 12'h201, 12'h482, 12'h804}; // Events, flags
	initial forever #5 core_clk = ~core_clk;
	lcirq_host host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
	lcirq_link_change dut (.core_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata_ff, .p1_ana_link_event(ev[0]), .p1_mii_link_event(ev[1]),
		.p2_ana_link_event(ev[2]), .p3_mii_link_event(ev[3]), .irq_out_n_ff);
	// ======== Checks: read data and pin compared together
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic ie);
		host.rd(a);
		cmp_count++;
		err_total += int'({reg_rdata_ff, irq_out_n_ff} !== {e, ie});
		if ({reg_rdata_ff, irq_out_n_ff} !== {e, ie}) $display("MISMATCH %0t at %h", $time, a);
	endtask
	task automatic wrap_up(input int extra);
		err_total += extra;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial #20000 wrap_up(1); // Run needs about 70 cycles
	initial begin
		repeat (8) @(posedge core_clk);
		#1 srst = 1'h0;
		@(posedge core_clk) #1 ev = 4'h2;
		@(posedge core_clk) #1 ev = 4'h0;
		host.wr(8'hBC, 8'h7E);
		rdchk(8'hBC, 8'h01, 1'h1);
		host.wr(8'hBB, 8'hFF);
		host.wr(8'hBC, 8'hFF);
		foreach (rows[i]) begin
			@(posedge core_clk) #1 ev = rows[i][11:8];
			@(posedge core_clk) #1 ev = 4'h0;
			rdchk(8'hBC, rows[i][7:0], 1'h0);
			host.wr(8'hBC, rows[i][7:0]);
			rdchk(8'hBC, 8'h00, 1'h1);
		end
		// Zero bits of a clear write must keep their flags
		@(posedge core_clk) #1 ev = 4'h4;
		@(posedge core_clk) #1 ev = 4'h0;
		host.wr(8'hBC, 8'h80);
		rdchk(8'hBC, 8'h02, 1'h0);
		host.wr(8'hBC, 8'h02);
		// Event and clear in one cycle: the event wins
		fork
			host.wr(8'hBC, 8'h01);
			begin
				@(posedge core_clk) #1 ev = 4'h2;
				@(posedge core_clk) #1 ev = 4'h0;
			end
		join
		rdchk(8'hBC, 8'h01, 1'h0);
		rdchk(8'hBD, 8'h00, 1'h0);
		host.wr(8'hBC, 8'h01);
		rdchk(8'hBB, 8'hFF, 1'h1);
		srst = 1'h1;
		@(posedge core_clk) #1 srst = 1'h0;
		rdchk(8'hBB, 8'h00, 1'h1);
		wrap_up(0);
	end
endmodule // lcirq_link_change_tb
